// >>> hdl/macmv_pkg.sv
package macmv_pkg;

  // ==========================================================
  // Operation codes presented by the decode stage
  typedef enum logic [3:0] {
    MACMV_OP_NONE = 4'h0,
    MACMV_OP_MACS = 4'h1,
    MACMV_OP_MACSU = 4'h2,
    MACMV_OP_MACU = 4'h3,
    MACMV_OP_CRCOPY = 4'h4,
    MACMV_OP_EXC2CR = 4'h5,
    MACMV_OP_RDCR = 4'h6,
    MACMV_OP_RDDEV = 4'h7,
    MACMV_OP_RDMSR = 4'h8,
    MACMV_OP_RDSPR = 4'h9,
    MACMV_OP_RDTB = 4'ha
  } macmv_op_e;

  // Accumulate kinds for the arithmetic unit
  typedef enum logic [1:0] {
    MACMV_K_SSAT = 2'h0,
    MACMV_K_USAT = 2'h1,
    MACMV_K_UMOD = 2'h3
  } macmv_kind_e;

  // ==========================================================
  // Field layout, bit 0 is the most significant (big-endian numbering)
  localparam int MACMV_INSN_SPRBIT = 20; // Instruction bit 11, LSB-0 index
  localparam int MACMV_INSN_RCBIT = 0;   // Instruction bit 31, LSB-0 index
  localparam int MACMV_XER_SO = 31;
  localparam int MACMV_XER_OV = 30;
  localparam int MACMV_XER_CA = 29;
  localparam int MACMV_CR0_HI = 31;

  // Time-base register numbers and their encoded fields
  localparam logic [9:0] MACMV_TB_LOW_NUM = 10'h10c;
  localparam logic [9:0] MACMV_TB_HIGH_NUM = 10'h10d;
  localparam logic [9:0] MACMV_TB_LOW_ENC = 10'h188;
  localparam logic [9:0] MACMV_TB_HIGH_ENC = 10'h1a8;

  // Reset values
  localparam logic [31:0] MACMV_CR_RST = 32'h0;
  localparam logic [31:0] MACMV_XER_RST = 32'h0;
  localparam logic [31:0] MACMV_WORD_RST = 32'h0;

  // Saturation limits
  localparam logic [31:0] MACMV_SMAX = 32'h7fffffff;
  localparam logic [31:0] MACMV_SMIN = 32'h80000000;

  // ==========================================================
  // Decoded instruction from the decode stage
  typedef struct packed {
    logic valid;
    macmv_op_e op;
    logic [4:0] rt;
    logic [9:0] fld;      // Split register field, or field selectors
    logic [2:0] dst_fld;
    logic [2:0] src_fld;
    logic oe;
    logic [31:0] insn;    // Raw word, LSB-0
  } macmv_req_s;

  // Result of the accumulate unit
  typedef struct packed {
    logic [31:0] value;
    logic ovf;
  } macmv_acc_s;

  // Swap the two 5-bit halves of a split register field
  function automatic logic [9:0] macmv_swap(input logic [9:0] enc);
    return {enc[4:0], enc[9:5]};
  endfunction

  // Four-bit condition from a signed result and the summary flag
  function automatic logic [3:0] macmv_cond(input logic [31:0] v, input logic so);
    return {v[31], (~v[31]) & (v != 32'h0), (v == 32'h0), so};
  endfunction

endpackage

// >>> hdl/macmv_acc.sv
`timescale 1ns/1ps
module macmv_acc import macmv_pkg::*; (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic [31:0] t,
  input wire macmv_kind_e kind,
  output macmv_acc_s res
);

  logic [31:0] prod;
  logic [32:0] temp;

  // ==========================================================
  // Low-halfword product and 33-bit sum
  always_comb begin
    if (kind == MACMV_K_SSAT) begin
      prod = 32'($signed(a[15:0]) * $signed(b[15:0]));
    end else begin
      prod = 32'(a[15:0] * b[15:0]);
    end
    temp = {1'b0, prod} + {1'b0, t};
    res.value = temp[31:0];
    res.ovf = 1'b0;
    unique case (kind)
      MACMV_K_SSAT: begin
        // Sign of operands agree, sign of sum differs
        res.ovf = (prod[31] == t[31]) && (t[31] != temp[31]);
        if (res.ovf) begin
          res.value = t[31] ? MACMV_SMIN : MACMV_SMAX;
        end
      end
      MACMV_K_USAT: begin
        res.ovf = temp[32];
        res.value = temp[31:0] | {32{temp[32]}};
      end
      MACMV_K_UMOD: begin
        res.ovf = temp[32]; // Carry discarded from value
      end
    endcase
  end

endmodule

// >>> hdl/macmv_exec.sv
`timescale 1ns/1ps
// How it works
// - Multiply low halfwords, signed or unsigned, add target, keep 33-bit sum.
// - Signed saturate: detect overflow from signs, clamp to signed min or max.
// - Unsigned saturate: carry ORed into all bits gives all-ones on overflow.
// - Unsigned modulo: write low 32 sum bits, drop carry.
// - Condition field zero only with record flag; exception bits only with overflow-enable.
// - Copy one 4-bit condition field into another, others untouched.
// - Exception bits 0..3 go to chosen condition field, then are cleared.
// - Transfer is positional: summary, overflow, carry, reserved bit to the four flags.
// - Register moves with instruction bit 31 set may leave field zero undefined.
// - Read condition register copies all 32 bits to target.
// - Device read swaps field halves for number, loads that register.
// - Device and machine-state reads refused in user mode.
// - Machine-state read copies state register, alters nothing else.
// - Special read swaps halves; invalid numbers flag an illegal form.
// - Special read is privileged exactly when instruction bit 11 is set.
// - Time-base read swaps halves and copies the chosen time-base word.
// - Only numbers 268 and 269 select low and high time-base words.
// - Other time-base numbers return an undefined, here zero, result.
module macmv_exec import macmv_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire macmv_req_s REQ,
  input wire logic [31:0] SRC_A,
  input wire logic [31:0] SRC_B,
  input wire logic [31:0] SRC_T,
  input wire logic USER_MODE,
  input wire logic [31:0] MSR_VAL,
  input wire logic [31:0] DEV_RDATA,
  input wire logic DEV_VALID,
  input wire logic [31:0] SPR_RDATA,
  input wire logic SPR_VALID,
  input wire logic [63:0] TICK_BASE,
  output logic [9:0] DEV_NUM,
  output logic [9:0] SPR_NUM,
  output logic WB_VALID,
  output logic [4:0] WB_GPR,
  output logic [31:0] WB_DATA,
  output logic PRIV_FAULT,
  output logic ILLEGAL_FORM,
  output logic [31:0] COND_REG,
  output logic [31:0] EXC_REG
);

  // ==========================================================
  // Accumulate unit
  macmv_kind_e kind;
  macmv_acc_s acc;

  always_comb begin
    unique case (REQ.op)
      MACMV_OP_MACSU: kind = MACMV_K_USAT;
      MACMV_OP_MACU: kind = MACMV_K_UMOD;
      default: kind = MACMV_K_SSAT;
    endcase
  end

  macmv_acc u_acc (
    .a(SRC_A),
    .b(SRC_B),
    .t(SRC_T),
    .kind(kind),
    .res(acc)
  );

  // ==========================================================
  // Register number decode for split fields
  logic [9:0] num_now;
  assign num_now = macmv_swap(REQ.fld);

  // ==========================================================
  // Decode helpers

  // Four-bit condition field n, field zero in the top nibble
  function automatic logic [3:0] crf_get(input logic [31:0] cr, input logic [2:0] n);
    return cr[{~n, 2'b11} -: 4];
  endfunction

  // Condition register with field n replaced, other fields kept
  function automatic logic [31:0] crf_put(input logic [31:0] cr, input logic [2:0] n, input logic [3:0] v);
    logic [31:0] res;
    res = cr;
    res[{~n, 2'b11} -: 4] = v;
    return res;
  endfunction

  // One of the three accumulate forms
  function automatic logic mac_op(input macmv_op_e op);
    return (op == MACMV_OP_MACS) || (op == MACMV_OP_MACSU) || (op == MACMV_OP_MACU);
  endfunction

  // ==========================================================
  // Request classification shared by all groups
  logic is_mac;
  logic deny_now;
  logic bad_now;

  // Refusal and invalid-number decode of the current request
  always_comb begin
    is_mac = REQ.valid && mac_op(REQ.op);
    deny_now = 1'b0;
    bad_now = 1'b0;
    if (REQ.valid) begin
      unique case (REQ.op)
        MACMV_OP_RDDEV: begin
          deny_now = USER_MODE;
          bad_now = !USER_MODE && !DEV_VALID;
        end
        MACMV_OP_RDMSR: begin
          deny_now = USER_MODE;
        end
        MACMV_OP_RDSPR: begin
          // Bit 11 alone decides whether the number is guarded
          deny_now = USER_MODE && REQ.insn[MACMV_INSN_SPRBIT];
          bad_now = !deny_now && !SPR_VALID;
        end
        default: begin
          deny_now = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Condition and exception registers
  logic [31:0] cr_reg, cr_next;
  logic [31:0] xer_reg, xer_next;
  logic so_now;

  // Next values of the condition and exception registers
  always_comb begin
    cr_next = cr_reg;
    xer_next = xer_reg;
    so_now = xer_reg[MACMV_XER_SO];
    if (is_mac) begin
      if (REQ.oe) begin
        // Summary overflow is sticky, overflow follows this result
        so_now = xer_reg[MACMV_XER_SO] | acc.ovf;
        xer_next[MACMV_XER_OV] = acc.ovf;
        xer_next[MACMV_XER_SO] = so_now;
      end
      if (REQ.insn[MACMV_INSN_RCBIT]) begin
        cr_next = crf_put(cr_reg, 3'h0, macmv_cond(acc.value, so_now));
      end
    end else if (REQ.valid) begin
      unique case (REQ.op)
        MACMV_OP_CRCOPY: begin
          cr_next = crf_put(cr_reg, REQ.dst_fld, crf_get(cr_reg, REQ.src_fld));
        end
        MACMV_OP_EXC2CR: begin
          // Positional: summary, overflow, carry, reserved to less, greater, equal, summary
          cr_next = crf_put(cr_reg, REQ.dst_fld, xer_reg[MACMV_XER_SO -: 4]);
          xer_next[MACMV_XER_SO -: 4] = 4'h0;
        end
        default: begin
          // Moves with bit 31 set simply leave field zero as it was
          cr_next = cr_reg;
        end
      endcase
    end
  end

  // Condition and exception state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cr_reg <= MACMV_CR_RST;
      xer_reg <= MACMV_XER_RST;
    end else begin
      cr_reg <= cr_next;
      xer_reg <= xer_next;
    end
  end

  // ==========================================================
  // Write-back to the general register file
  logic wb_valid_reg, wb_valid_next;
  logic [4:0] wb_gpr_reg, wb_gpr_next;
  logic [31:0] wb_data_reg, wb_data_next;

  // Result selection per instruction; data holds when nothing is written
  always_comb begin
    wb_valid_next = 1'b0;
    wb_gpr_next = wb_gpr_reg;
    wb_data_next = wb_data_reg;
    if (REQ.valid) begin
      wb_gpr_next = REQ.rt;
      if (is_mac) begin
        wb_valid_next = 1'b1;
        wb_data_next = acc.value;
      end else begin
        unique case (REQ.op)
          MACMV_OP_RDCR: begin
            wb_valid_next = 1'b1;
            wb_data_next = cr_reg;
          end
          MACMV_OP_RDDEV: begin
            if (!deny_now && !bad_now) begin
              wb_valid_next = 1'b1;
              wb_data_next = DEV_RDATA;
            end
          end
          MACMV_OP_RDMSR: begin
            if (!deny_now) begin
              wb_valid_next = 1'b1;
              wb_data_next = MSR_VAL;
            end
          end
          MACMV_OP_RDSPR: begin
            if (!deny_now && !bad_now) begin
              wb_valid_next = 1'b1;
              wb_data_next = SPR_RDATA;
            end
          end
          MACMV_OP_RDTB: begin
            wb_valid_next = 1'b1;
            if (num_now == MACMV_TB_LOW_NUM) begin
              wb_data_next = TICK_BASE[31:0];
            end else if (num_now == MACMV_TB_HIGH_NUM) begin
              wb_data_next = TICK_BASE[63:32];
            end else begin
              // Any other number reads as zero
              wb_data_next = MACMV_WORD_RST;
            end
          end
          default: begin
            wb_valid_next = 1'b0;
          end
        endcase
      end
    end
  end

  // Write-back state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wb_valid_reg <= 1'b0;
      wb_gpr_reg <= 5'h0;
      wb_data_reg <= MACMV_WORD_RST;
    end else begin
      wb_valid_reg <= wb_valid_next;
      wb_gpr_reg <= wb_gpr_next;
      wb_data_reg <= wb_data_next;
    end
  end

  // ==========================================================
  // Refusal pulses
  logic priv_reg, priv_next;
  logic ill_reg, ill_next;

  // One-cycle pulses for refused or malformed reads
  always_comb begin
    priv_next = deny_now;
    ill_next = bad_now;
  end

  // Refusal state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      priv_reg <= 1'b0;
      ill_reg <= 1'b0;
    end else begin
      priv_reg <= priv_next;
      ill_reg <= ill_next;
    end
  end

  // ==========================================================
  // Last decoded device and special register numbers
  logic [9:0] dev_num_reg, dev_num_next;
  logic [9:0] spr_num_reg, spr_num_next;

  // Numbers captured on every device or special read
  always_comb begin
    dev_num_next = dev_num_reg;
    spr_num_next = spr_num_reg;
    if (REQ.valid && REQ.op == MACMV_OP_RDDEV) begin
      dev_num_next = num_now;
    end
    if (REQ.valid && REQ.op == MACMV_OP_RDSPR) begin
      spr_num_next = num_now;
    end
  end

  // Number state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dev_num_reg <= 10'h0;
      spr_num_reg <= 10'h0;
    end else begin
      dev_num_reg <= dev_num_next;
      spr_num_reg <= spr_num_next;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign COND_REG = cr_reg;
  assign EXC_REG = xer_reg;
  assign WB_VALID = wb_valid_reg;
  assign WB_GPR = wb_gpr_reg;
  assign WB_DATA = wb_data_reg;
  assign PRIV_FAULT = priv_reg;
  assign ILLEGAL_FORM = ill_reg;
  assign DEV_NUM = dev_num_reg;
  assign SPR_NUM = spr_num_reg;

endmodule

// >>> bench/macmv_exec_monitor.sv
`timescale 1ns/1ps
module macmv_exec_monitor import macmv_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire macmv_req_s REQ,
  input wire logic USER_MODE,
  input wire logic [31:0] MSR_VAL,
  input wire logic DEV_VALID,
  input wire logic [31:0] SPR_RDATA,
  input wire logic SPR_VALID,
  input wire logic [63:0] TICK_BASE,
  input wire logic WB_VALID,
  input wire logic [31:0] WB_DATA,
  input wire logic PRIV_FAULT,
  input wire logic ILLEGAL_FORM,
  input wire logic [31:0] COND_REG,
  input wire logic [31:0] EXC_REG
);
  // ==========================================================
  // Port relations
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  chk_fault_no_wb: assert property (PRIV_FAULT |-> !WB_VALID)
    else $error("write-back on refusal");
  chk_dev_user: assert property (REQ.valid && REQ.op == MACMV_OP_RDDEV && USER_MODE |=> PRIV_FAULT)
    else $error("user device read kept");
  chk_dev_bad: assert property (REQ.valid && REQ.op == MACMV_OP_RDDEV && !USER_MODE && !DEV_VALID |=> ILLEGAL_FORM && !WB_VALID)
    else $error("bad device number kept");
  chk_msr_copy: assert property (REQ.valid && REQ.op == MACMV_OP_RDMSR && !USER_MODE |=> WB_VALID && WB_DATA == $past(MSR_VAL))
    else $error("state read wrong");
  chk_cr_read: assert property (REQ.valid && REQ.op == MACMV_OP_RDCR |=> WB_VALID && WB_DATA == $past(COND_REG))
    else $error("condition read wrong");
  chk_tick_low: assert property (REQ.valid && REQ.op == MACMV_OP_RDTB && REQ.fld == 10'h188 |=> WB_DATA == $past(TICK_BASE[31:0]))
    else $error("tick low wrong");
  chk_spr_priv: assert property (REQ.valid && REQ.op == MACMV_OP_RDSPR && USER_MODE |=> PRIV_FAULT == $past(REQ.insn[20]))
    else $error("special privilege wrong");
  chk_spr_data: assert property (REQ.valid && REQ.op == MACMV_OP_RDSPR && SPR_VALID && !(USER_MODE && REQ.insn[20]) |=> WB_VALID && WB_DATA == $past(SPR_RDATA))
    else $error("special read wrong");
  chk_exc_move: assert property (REQ.valid && REQ.op == MACMV_OP_EXC2CR |=> EXC_REG[31:28] == 4'h0 && COND_REG[31 - 4 * $past(REQ.dst_fld) -: 4] == $past(EXC_REG[31:28]))
    else $error("exception move wrong");
  chk_oe_hold: assert property (REQ.valid && REQ.op inside {MACMV_OP_MACS, MACMV_OP_MACSU, MACMV_OP_MACU} && !REQ.oe |=> $stable(EXC_REG))
    else $error("exception bits changed");
  chk_rc_hold: assert property (REQ.valid && REQ.op inside {MACMV_OP_MACS, MACMV_OP_MACSU, MACMV_OP_MACU} && !REQ.insn[0] |=> $stable(COND_REG[31:28]))
    else $error("field zero changed");
  // Main scenarios reached
  cov_mac_ovf: cover property (REQ.valid && REQ.op == MACMV_OP_MACS ##1 EXC_REG[30]);
  cov_fault: cover property (PRIV_FAULT);
  cov_illegal: cover property (ILLEGAL_FORM);
endmodule

bind macmv_exec macmv_exec_monitor u_mon (.CLK(CLK), .RST(RST), .REQ(REQ), .USER_MODE(USER_MODE), .MSR_VAL(MSR_VAL),
  .DEV_VALID(DEV_VALID), .SPR_RDATA(SPR_RDATA), .SPR_VALID(SPR_VALID), .TICK_BASE(TICK_BASE), .WB_VALID(WB_VALID),
  .WB_DATA(WB_DATA), .PRIV_FAULT(PRIV_FAULT), .ILLEGAL_FORM(ILLEGAL_FORM), .COND_REG(COND_REG), .EXC_REG(EXC_REG));

// >>> bench/macmv_exec_tb.sv
`timescale 1ns/1ps
module macmv_exec_tb import macmv_pkg::*;;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic user_mode = 1'b0;
  logic dev_valid = 1'b0;
  logic spr_valid = 1'b0;
  macmv_req_s req = '0;
  logic [31:0] src_a = 32'h0, src_b = 32'h0, src_t = 32'h0, msr_val = 32'h0, dev_rdata = 32'h0, spr_rdata = 32'h0;
  logic [63:0] tick_base = 64'h0;
  logic [9:0] dev_num, spr_num;
  logic wb_valid, priv_fault, illegal_form;
  logic [4:0] wb_gpr;
  logic [31:0] wb_data, cond_reg, exc_reg;
  int miscompares = 0;
  int num_checks = 0;
  macmv_exec u_dut (.CLK(clk), .RST(rst), .REQ(req), .SRC_A(src_a), .SRC_B(src_b), .SRC_T(src_t),
    .USER_MODE(user_mode), .MSR_VAL(msr_val), .DEV_RDATA(dev_rdata), .DEV_VALID(dev_valid),
    .SPR_RDATA(spr_rdata), .SPR_VALID(spr_valid), .TICK_BASE(tick_base), .DEV_NUM(dev_num),
    .SPR_NUM(spr_num), .WB_VALID(wb_valid), .WB_GPR(wb_gpr), .WB_DATA(wb_data), .PRIV_FAULT(priv_fault),
    .ILLEGAL_FORM(illegal_form), .COND_REG(cond_reg), .EXC_REG(exc_reg));
  // 100 ns clock
  initial forever #50 clk = ~clk;
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One instruction, answer visible on return
  task automatic issue(input macmv_op_e op, input logic [9:0] fld, input logic [2:0] dst, input logic [31:0] insn,
      input logic oe);
    @(posedge clk);
    #1;
    req = '{valid: 1'b1, op: op, rt: 5'h03, fld: fld, dst_fld: dst, src_fld: 3'h0, oe: oe, insn: insn};
    @(posedge clk);
    #1;
    req.valid = 1'b0;
  endtask
  task automatic pulses(input logic [2:0] exp);
    chk("wb/fault/illegal", {29'h0, exp}, {29'h0, wb_valid, priv_fault, illegal_form});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic mac(input macmv_op_e op, input logic [31:0] a, b, t, input logic oe, rc,
      input logic [31:0] val, input logic [1:0] exc, input logic [3:0] cr0);
    src_a = a;
    src_b = b;
    src_t = t;
    issue(op, 10'h0, 3'h0, {31'h0, rc}, oe);
    pulses(3'b100);
    chk("mac result", val, wb_data);
    chk("mac gpr", 32'h3, {27'h0, wb_gpr});
    chk("mac so/ov", {30'h0, exc}, {30'h0, exc_reg[31:30]});
    chk("mac field zero", {28'h0, cr0}, {28'h0, cond_reg[31:28]});
  endtask
  task automatic cr_moves();
    issue(MACMV_OP_EXC2CR, 10'h0, 3'h5, 32'h0, 1'b0);
    chk("exc cleared", 32'h0, {28'h0, exc_reg[31:28]});
    chk("field five", 32'h8, {28'h0, cond_reg[11:8]});
    issue(MACMV_OP_CRCOPY, 10'h0, 3'h7, 32'h0, 1'b0);
    chk("cr copy", 32'h50000805, cond_reg);
    issue(MACMV_OP_RDCR, 10'h0, 3'h0, 32'h1, 1'b0);
    chk("cr read", 32'h50000805, wb_data);
    chk("cr kept", 32'h50000805, cond_reg);
  endtask
  task automatic priv_reads();
    msr_val = 32'h0000c0de;
    dev_rdata = 32'h13572468;
    spr_rdata = 32'h5a5a0001;
    dev_valid = 1'b1;
    spr_valid = 1'b1;
    user_mode = 1'b1;
    issue(MACMV_OP_RDMSR, 10'h0, 3'h0, 32'h0, 1'b0);
    pulses(3'b010);
    issue(MACMV_OP_RDDEV, 10'h0a1, 3'h0, 32'h0, 1'b0);
    pulses(3'b010);
    issue(MACMV_OP_RDSPR, 10'h0a1, 3'h0, 32'h00100000, 1'b0);
    pulses(3'b010);
    issue(MACMV_OP_RDSPR, 10'h0a1, 3'h0, 32'h0, 1'b0);
    pulses(3'b100);
    chk("spr data", 32'h5a5a0001, wb_data);
    user_mode = 1'b0;
    issue(MACMV_OP_RDMSR, 10'h0, 3'h0, 32'h0, 1'b0);
    chk("msr data", 32'h0000c0de, wb_data);
    issue(MACMV_OP_RDDEV, 10'h0a1, 3'h0, 32'h0, 1'b0);
    chk("dev data", 32'h13572468, wb_data);
    dev_valid = 1'b0;
    spr_valid = 1'b0;
    issue(MACMV_OP_RDDEV, 10'h0a1, 3'h0, 32'h0, 1'b0);
    pulses(3'b001);
    chk("dev num", 32'h25, {22'h0, dev_num});
    issue(MACMV_OP_RDSPR, 10'h0a1, 3'h0, 32'h0, 1'b0);
    pulses(3'b001);
    chk("spr num", 32'h25, {22'h0, spr_num});
  endtask
  task automatic tick_reads();
    tick_base = 64'h89abcdef01234567;
    issue(MACMV_OP_RDTB, 10'h188, 3'h0, 32'h0, 1'b0);
    chk("tick low", 32'h01234567, wb_data);
    issue(MACMV_OP_RDTB, 10'h1a8, 3'h0, 32'h0, 1'b0);
    chk("tick high", 32'h89abcdef, wb_data);
    issue(MACMV_OP_RDTB, 10'h000, 3'h0, 32'h0, 1'b0);
    chk("tick other", MACMV_WORD_RST, wb_data);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    mac(MACMV_OP_MACS, 32'h1, 32'h1, 32'h7fffffff, 1'b1, 1'b1, 32'h7fffffff, 2'b11, 4'h5);
    mac(MACMV_OP_MACS, 32'h0000ffff, 32'h1, 32'h80000000, 1'b0, 1'b0, 32'h80000000, 2'b11, 4'h5);
    mac(MACMV_OP_MACSU, 32'hffff, 32'hffff, 32'hffffffff, 1'b1, 1'b1, 32'hffffffff, 2'b11, 4'h9);
    mac(MACMV_OP_MACU, 32'habcd0002, 32'h12340003, 32'hfffffffe, 1'b1, 1'b1, 32'h4, 2'b11, 4'h5);
    mac(MACMV_OP_MACU, 32'h1, 32'h1, 32'h0, 1'b1, 1'b1, 32'h1, 2'b10, 4'h5);
    mac(MACMV_OP_MACS, 32'h0000fffe, 32'h3, 32'h5, 1'b1, 1'b0, 32'hffffffff, 2'b10, 4'h5);
    cr_moves();
    priv_reads();
    tick_reads();
    wrap_up();
  end
  // Run limit
  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end
endmodule
